// ==== irr_router.sv ====
// Routes peripheral service requests onto interrupt node lines.
// Assumes flags and enables arrive as synchronous levels from peripherals.
// Notes on behaviour
// - UART receive requests mirror receive_done_flag on nodes 10 and 11 until cleared.
// - UART transmit requests mirror transmit_done_flag, gated by transmit enable, same node.
// - Four capture_compare_unit lines go to nodes 4..7 as 2-cycle levels latched in flags.
// - Sync byte error and end flags drive node 10 under one sync_irq_enable.
// - Each request pairs flag and enable; reference to 3, serial to 8/9, driver to 14.
`timescale 1ns/1ps
`include "irr_params.svh"
module irr_router
    import irr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Five volt reference: overload, upper, lower
    input wire logic [2:0] i_vref_flag,
    input wire logic [2:0] i_vref_en,
    // Capture compare service lines and flag clears
    input wire logic [3:0] i_cc_req,
    input wire logic [3:0] i_cc_clr,
    input wire logic [3:0] i_cc_en,
    // Serial channels: error, transmit, receive
    input wire logic [2:0] i_ssc1_flag,
    input wire logic [2:0] i_ssc1_en,
    input wire logic [2:0] i_ssc2_flag,
    input wire logic [2:0] i_ssc2_en,
    // UARTs, index 0 first, 1 second
    input wire logic [1:0] i_receive_done_flag,
    input wire logic [1:0] i_receive_en,
    input wire logic [1:0] i_transmit_done_flag,
    input wire logic [1:0] i_transmit_en,
    // LIN sync detection
    input wire logic i_sync_byte_error_flag,
    input wire logic i_sync_byte_end_flag,
    input wire logic i_sync_irq_enable,
    // Other node 10 sources: timer overflow, timer ext, over temp, over current, timeout
    input wire logic [4:0] i_n10_flag,
    input wire logic [4:0] i_n10_en,
    // Other node 11 sources: timer overflow, timer ext, external int 2
    input wire logic [2:0] i_n11_flag,
    input wire logic [2:0] i_n11_en,
    // External interrupts: node 12 has two sources, node 13 one
    input wire logic [1:0] i_ext0_flag,
    input wire logic [1:0] i_ext0_en,
    input wire logic i_ext1_flag,
    input wire logic i_ext1_en,
    // Bridge driver supply thresholds: lower, upper
    input wire logic [1:0] i_bridge_driver_flag,
    input wire logic [1:0] i_bridge_driver_en,
    // Outputs
    output logic [3:0] o_cc_flag,
    output irr_nodes_type o_interrupt_node_line
);
    typedef struct packed {
        irr_nodes_type nodes;
    } irr_state_type;

    irr_state_type state_q;
    irr_state_type state_d;
    logic [3:0] cc_level;

    genvar gi;
    generate
        for (gi = 0; gi < `IRR_CC_LINES; gi++)
        begin : g_cc
            irr_pulse_latch u_latch (
                .i_sys_clk(i_sys_clk),
                .i_srst(i_srst),
                .i_req(i_cc_req[gi]),
                .i_clr(i_cc_clr[gi]),
                .o_flag(o_cc_flag[gi]),
                .o_level(cc_level[gi])
            );
            cc_node_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                i_cc_req[gi] ##1 i_cc_en[gi] |=> o_interrupt_node_line[`IRR_NODE_CC0 + gi])
                else $error("capture compare request not on its node");
            cc_end_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                i_cc_req[gi] ##1 !i_cc_req[gi] [*3] |=> !o_interrupt_node_line[`IRR_NODE_CC0 + gi])
                else $error("capture compare level longer than two cycles");
            cc_off_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                !i_cc_en[gi] |=> !o_interrupt_node_line[`IRR_NODE_CC0 + gi])
                else $error("disabled capture compare line on its node");
            cc_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                i_cc_clr[gi] && !i_cc_req[gi] |=> !o_cc_flag[gi])
                else $error("capture compare flag not cleared");
            cc_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                o_cc_flag[gi] && !i_cc_clr[gi] |=> o_cc_flag[gi])
                else $error("capture compare flag lost without clear");
        end
    endgenerate

    always_comb
    begin
        state_d = '0;
        state_d.nodes[`IRR_NODE_VREF] = |(i_vref_flag & i_vref_en);
        for (int k = 0; k < `IRR_CC_LINES; k++)
        begin
            state_d.nodes[`IRR_NODE_CC0 + k] = cc_level[k] & i_cc_en[k];
        end
        state_d.nodes[`IRR_NODE_SSC1] = |(i_ssc1_flag & i_ssc1_en);
        state_d.nodes[`IRR_NODE_SSC2] = |(i_ssc2_flag & i_ssc2_en);
        state_d.nodes[`IRR_NODE_UART1] = (i_receive_done_flag[0] & i_receive_en[0])
            | (i_transmit_done_flag[0] & i_transmit_en[0])
            | ((i_sync_byte_error_flag | i_sync_byte_end_flag) & i_sync_irq_enable)
            | (|(i_n10_flag & i_n10_en));
        state_d.nodes[`IRR_NODE_UART2] = (i_receive_done_flag[1] & i_receive_en[1])
            | (i_transmit_done_flag[1] & i_transmit_en[1])
            | (|(i_n11_flag & i_n11_en));
        state_d.nodes[`IRR_NODE_EXT0] = |(i_ext0_flag & i_ext0_en);
        state_d.nodes[`IRR_NODE_EXT1] = i_ext1_flag & i_ext1_en;
        state_d.nodes[`IRR_NODE_BRIDGE_DRIVER] = |(i_bridge_driver_flag & i_bridge_driver_en);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_interrupt_node_line = state_q.nodes;

    // Node 10 and 11 requests
    uart_rx_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_receive_done_flag[0] && i_receive_en[0] |=> o_interrupt_node_line[10])
        else $error("uart1 receive not on node 10");
    uart2_rx_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_receive_done_flag[1] && i_receive_en[1] |=> o_interrupt_node_line[11])
        else $error("uart2 receive not on node 11");
    uart_tx_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_transmit_done_flag[1] && i_transmit_en[1] |=> o_interrupt_node_line[11])
        else $error("uart2 transmit not on node 11");
    uart1_tx_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_transmit_done_flag[0] && i_transmit_en[0] |=> o_interrupt_node_line[10])
        else $error("uart1 transmit not on node 10");
    sync_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_sync_byte_end_flag && i_sync_irq_enable |=> o_interrupt_node_line[10])
        else $error("sync end not on node 10");
    sync_err_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_sync_byte_error_flag && i_sync_irq_enable |=> o_interrupt_node_line[10])
        else $error("sync error not on node 10");
    node10_off_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !i_receive_en[0] && !i_transmit_en[0] && !i_sync_irq_enable && i_n10_en == 5'h0
        |=> !o_interrupt_node_line[10])
        else $error("node 10 set with all its enables off");
    node11_off_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !i_receive_en[1] && !i_transmit_en[1] && i_n11_en == 3'h0 |=> !o_interrupt_node_line[11])
        else $error("node 11 set with all its enables off");
    node10_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !i_receive_done_flag[0] && !i_transmit_done_flag[0] && !i_sync_byte_error_flag
        && !i_sync_byte_end_flag && i_n10_flag == 5'h0 |=> !o_interrupt_node_line[10])
        else $error("node 10 set with no source flag");
    node11_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !i_receive_done_flag[1] && !i_transmit_done_flag[1] && i_n11_flag == 3'h0
        |=> !o_interrupt_node_line[11])
        else $error("node 11 set with no source flag");
    n10_other_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_n10_flag & i_n10_en) != 5'h0 |=> o_interrupt_node_line[10])
        else $error("other node 10 source not routed");
    n11_other_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_n11_flag & i_n11_en) != 3'h0 |=> o_interrupt_node_line[11])
        else $error("other node 11 source not routed");

    // Capture compare, reference and serial nodes
    cc_map_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_cc_req[2] ##1 i_cc_en[2] |=> o_interrupt_node_line[6])
        else $error("capture compare line 2 not on node 6");
    vref_map_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_vref_flag[1] && i_vref_en[1] |=> o_interrupt_node_line[3])
        else $error("reference monitor not on node 3");
    vref_any_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_vref_flag & i_vref_en) != 3'h0 |=> o_interrupt_node_line[3])
        else $error("reference source not on node 3");
    vref_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_vref_flag & i_vref_en) == 3'h0 |=> !o_interrupt_node_line[3])
        else $error("node 3 set with no enabled source");
    ssc1_map_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_ssc1_flag & i_ssc1_en) != 3'h0 |=> o_interrupt_node_line[8])
        else $error("serial channel 1 request not on node 8");
    idle_node_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_ssc1_flag & i_ssc1_en) == 3'h0 |=> !o_interrupt_node_line[8])
        else $error("node 8 set with no enabled source");
    ssc2_map_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_ssc2_flag & i_ssc2_en) != 3'h0 |=> o_interrupt_node_line[9])
        else $error("serial channel 2 request not on node 9");
    ssc2_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_ssc2_flag & i_ssc2_en) == 3'h0 |=> !o_interrupt_node_line[9])
        else $error("node 9 set with no enabled source");

    // External, driver supply and unmapped nodes
    ext0_map_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_ext0_flag & i_ext0_en) != 2'h0 |=> o_interrupt_node_line[12])
        else $error("external request not on node 12");
    ext0_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_ext0_flag & i_ext0_en) == 2'h0 |=> !o_interrupt_node_line[12])
        else $error("node 12 set with no enabled source");
    ext1_map_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ext1_flag && i_ext1_en |=> o_interrupt_node_line[13])
        else $error("external request not on node 13");
    ext1_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !(i_ext1_flag && i_ext1_en) |=> !o_interrupt_node_line[13])
        else $error("node 13 set with no enabled source");
    bridge_driver_map_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_bridge_driver_flag & i_bridge_driver_en) == 2'h0 |=> !o_interrupt_node_line[14])
        else $error("node 14 set without source");
    bridge_driver_set_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_bridge_driver_flag & i_bridge_driver_en) != 2'h0 |=> o_interrupt_node_line[14])
        else $error("driver supply threshold not on node 14");
    unused_nodes_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_interrupt_node_line[2:0] == 3'h0 && !o_interrupt_node_line[15])
        else $error("unmapped node line set");
    reset_clear_a: assert property (@(posedge i_sys_clk)
        i_srst |=> o_interrupt_node_line == 16'h0000 && o_cc_flag == 4'h0)
        else $error("outputs not cleared by reset");
endmodule : irr_router

// ==== irr_params.svh ====
// Constants for the interrupt request routing block.
// Assumes inclusion by the package and design files only.
`ifndef IRR_PARAMS_SVH
`define IRR_PARAMS_SVH
`define IRR_NODE_COUNT 16
`define IRR_NODE_VREF 3
`define IRR_NODE_CC0 4
`define IRR_NODE_SSC1 8
`define IRR_NODE_SSC2 9
`define IRR_NODE_UART1 10
`define IRR_NODE_UART2 11
`define IRR_NODE_EXT0 12
`define IRR_NODE_EXT1 13
`define IRR_NODE_BRIDGE_DRIVER 14
`define IRR_PULSE_CYCLES 2
`define IRR_CC_LINES 4
`endif

// ==== irr_pkg.sv ====
// Types for the interrupt request routing block.
// Assumes irr_params.svh is on the include path.
`include "irr_params.svh"
package irr_pkg;
    typedef logic [`IRR_NODE_COUNT-1:0] irr_nodes_type;
    typedef logic [1:0] irr_cnt_type;
endpackage : irr_pkg

// ==== irr_pulse_latch.sv ====
// Latches a pulsed service request and stretches it to a fixed length.
// Assumes single clock, synchronous reset.
`timescale 1ns/1ps
`include "irr_params.svh"
module irr_pulse_latch
    import irr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Request
    input wire logic i_req,
    input wire logic i_clr,
    // Outputs
    output logic o_flag,
    output logic o_level
);
    typedef struct packed {
        logic flag;
        irr_cnt_type cnt;
    } irr_pl_state_type;

    irr_pl_state_type state_q;
    irr_pl_state_type state_d;

    always_comb
    begin
        state_d = state_q;
        if (i_clr)
        begin
            state_d.flag = 1'b0;
        end
        if (i_req)
        begin
            state_d.flag = 1'b1;
            state_d.cnt = 2'(`IRR_PULSE_CYCLES);
        end
        else if (state_q.cnt != 2'h0)
        begin
            state_d.cnt = state_q.cnt - 2'h1;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_flag = state_q.flag;
    assign o_level = state_q.cnt != 2'h0;

    pulse_len_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_req ##1 !i_req |-> o_level ##1 o_level)
        else $error("stretched request shorter than two cycles");
    flag_set_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_req |=> o_flag)
        else $error("request flag not latched");
    flag_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_clr && !i_req |=> !o_flag)
        else $error("request flag not cleared");
endmodule : irr_pulse_latch

// ==== irr_core_model.sv ====
// Core-side model: records every node line it has seen.
// Assumes the router clock and reset.
`timescale 1ns/1ps
module irr_core_model
    import irr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Node lines in, seen set out
    input wire irr_nodes_type i_interrupt_node_line,
    output irr_nodes_type o_pending
);
    irr_nodes_type pending_q;
    assign o_pending = pending_q;
    // Levels sampled each edge
    always_ff @(posedge i_sys_clk)
    begin
        pending_q <= i_srst ? '0 : (pending_q | i_interrupt_node_line);
    end
endmodule : irr_core_model

// ==== irr_tb.sv ====
// Self-checking bench for the request router.
// Assumes irr_pkg and the router compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench
    import irr_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [27:0] f = '0;
    logic [27:0] e = '0;
    logic [3:0] req = '0;
    logic [3:0] clr = '0;
    logic [3:0] cen = '0;
    logic [3:0] ccf;
    irr_nodes_type node;
    irr_nodes_type seen;
    int failures = 0;
    int cmp_count = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    irr_router uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_vref_flag(f[2:0]),
        .i_vref_en(e[2:0]), .i_cc_req(req), .i_cc_clr(clr), .i_cc_en(cen),
        .i_ssc1_flag(f[5:3]), .i_ssc1_en(e[5:3]), .i_ssc2_flag(f[8:6]), .i_ssc2_en(e[8:6]),
        .i_receive_done_flag(f[10:9]), .i_receive_en(e[10:9]),
        .i_transmit_done_flag(f[12:11]), .i_transmit_en(e[12:11]),
        .i_sync_byte_error_flag(f[13]), .i_sync_byte_end_flag(f[14]),
        .i_sync_irq_enable(e[13]), .i_n10_flag(f[19:15]), .i_n10_en(e[19:15]),
        .i_n11_flag(f[22:20]), .i_n11_en(e[22:20]), .i_ext0_flag(f[24:23]),
        .i_ext0_en(e[24:23]), .i_ext1_flag(f[25]), .i_ext1_en(e[25]),
        .i_bridge_driver_flag(f[27:26]), .i_bridge_driver_en(e[27:26]),
        .o_cc_flag(ccf), .o_interrupt_node_line(node));
    irr_core_model core (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_interrupt_node_line(node), .o_pending(seen));
    function automatic int node_of(input int k);
        if (k < 3) return 3;
        if (k < 6) return 8;
        if (k < 9) return 9;
        if (k == 10 || k == 12) return 11;
        if (k < 20) return 10;
        if (k < 23) return 11;
        if (k < 25) return 12;
        return (k == 25) ? 13 : 14;
    endfunction : node_of
    task automatic apply(input logic [27:0] nf, input logic [27:0] ne);
        @(posedge i_sys_clk);
        f <= nf;
        e <= ne;
        @(posedge i_sys_clk);
        #1;
    endtask : apply
    task automatic step();
        @(posedge i_sys_clk);
        #1;
    endtask : step
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (5000) @(posedge i_sys_clk);
        failures++;
        end_of_test();
    end
    initial
    begin
        repeat (8) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        #1;
        `CHK({ccf, node}, 20'h00000)
        for (int k = 0; k < 28; k++)
        begin
            apply(28'h1 << k, (k == 14) ? 28'h0002000 : 28'h1 << k);
            `CHK(node, irr_nodes_type'(16'h0001 << node_of(k)))
            apply(28'h1 << k, 28'h0000000);
            `CHK(node, 16'h0000)
        end
        apply(28'h0000A00, 28'h0000A00);
        `CHK(node, 16'h0400)
        apply(28'h0000800, 28'h0000A00);
        `CHK(node, 16'h0400)
        apply(28'h0000800, 28'h0000200);
        `CHK(node, 16'h0000)
        apply(28'h0006000, 28'h0002000);
        `CHK(node, 16'h0400)
        apply(28'hFFFFFFF, 28'hFFFFFFF);
        `CHK(node, 16'h7F08)
        apply(28'h0000000, 28'hFFFFFFF);
        `CHK(node, 16'h0000)
        $display("Level routing test done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge i_sys_clk);
            cen <= 4'h1 << i;
            req <= 4'h1 << i;
            @(posedge i_sys_clk);
            req <= 4'h0;
            #1;
            `CHK({ccf, node}, {4'h1 << i, 16'h0000})
            step();
            `CHK(node, 16'h0010 << i)
            step();
            `CHK(node, 16'h0010 << i)
            @(posedge i_sys_clk);
            cen <= 4'h0;
            clr <= 4'h1 << i;
            #1;
            `CHK({ccf, node}, {4'h1 << i, 16'h0000})
            @(posedge i_sys_clk);
            clr <= 4'h0;
            req <= 4'h1 << i;
            #1;
            `CHK(ccf, 4'h0)
            @(posedge i_sys_clk);
            clr <= 4'h1 << i;
            #1;
            `CHK({ccf, node}, {4'h1 << i, 16'h0000})
            @(posedge i_sys_clk);
            req <= 4'h0;
            #1;
            `CHK(ccf, 4'h1 << i)
            @(posedge i_sys_clk);
            clr <= 4'h0;
            #1;
            `CHK(ccf, 4'h0)
        end
        $display("Capture compare test done");
        `CHK(seen, 16'h7FF8)
        end_of_test();
    end
endmodule : testbench
